// [logic/ppp_serial_phy.sv]
// Serial programming port physical layer with AXI4-Lite register access
`default_nettype none
`timescale 1ns/1ps
// Function
// - Frame is start, eight data, parity, two stop bits; nothing else.
// - Data bits travel least significant bit first.
// - Start bit is low, both stop bits are high.
// - Parity bit is even: xor of the eight data bits.
// - Break is low for twelve or more bit periods.
// - Serial logic follows the programmer's clock; device never makes it.
// - Drive changes on falling edges, sampling on rising edges.
// - Receive mode by default; direction changes to transmit only on access-layer command.
// - After start, shift bits in through second stop, then hand over byte.
// - Stop bit sampled zero raises frame error.
// - Accumulate parity, compare at the parity bit, mismatch raises parity error after frame.
// - Frame of all zeros raises break detection.
// - Any receive exception enters error state, receive mode, awaiting break.
// - Load shift register with byte, then shift one bit out per clock.
// - Drive zeros always; ones only in the first cycle of a run.
// - While driver is off in transmit, a low line is a collision.
// - Collision stops transmit, releases driver, forces receive and error state.
// - Error state is left only on a received break or when the port is disabled.
// - Releasing enable disables the port unless memory access enable is set.
// - Receive to transmit inserts guard time plus two idle bits; default 128.
module ppp_serial_phy (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ppp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ppp_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic prog_clock_in,
   input wire logic prog_data_line_in,
   output logic prog_data_line_out,
   output logic prog_data_line_oe,
   input wire logic prog_reset_n,
   input wire logic prog_reset_hv
);

   // Pin synchronisers
   logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
   logic dat_s1_ff, dat_s2_ff;
   logic rst_s1_ff, rst_s2_ff;
   logic hv_s1_ff, hv_s2_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_s1_ff <= 1'b1; // Idle level of the pin, so no false edge after reset
         clk_s2_ff <= 1'b1;
         clk_s3_ff <= 1'b1;
         dat_s1_ff <= 1'b1;
         dat_s2_ff <= 1'b1;
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= 1'b1;
         hv_s1_ff <= 1'b0;
         hv_s2_ff <= 1'b0;
      end else begin
         clk_s1_ff <= prog_clock_in;
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
         dat_s1_ff <= prog_data_line_in;
         dat_s2_ff <= dat_s1_ff;
         rst_s1_ff <= prog_reset_n;
         rst_s2_ff <= rst_s1_ff;
         hv_s1_ff <= prog_reset_hv;
         hv_s2_ff <= hv_s1_ff;
      end
   end

   // Edges of the programmer's clock; data and clock share the same delay
   wire link_rise = clk_s2_ff & ~clk_s3_ff;
   wire link_fall = ~clk_s2_ff & clk_s3_ff;
   wire line_bit = dat_s2_ff;

   // Register state
   logic nvm_en_ff;
   logic [7:0] guard_ff;
   logic port_en_ff;
   logic err_ff;
   logic [ppp_pkg::ST_STICKY_W-1:0] sticky_ff;
   logic [7:0] rx_data_ff;

   // Serial engine state
   ppp_pkg::ppp_state_type state_ff, nxt_state;
   logic [3:0] bit_cnt_ff, nxt_bit_cnt;
   logic [8:0] guard_cnt_ff, nxt_guard_cnt;
   logic [7:0] rx_sr_ff, nxt_rx_sr;
   logic par_ff, nxt_par;
   logic par_ok_ff, nxt_par_ok;
   logic stop_ok_ff, nxt_stop_ok;
   logic all_zero_ff, nxt_all_zero;
   logic [11:0] tx_sr_ff, nxt_tx_sr;
   logic out_ff, nxt_out;
   logic oe_ff, nxt_oe;
   logic prev_bit_ff, nxt_prev_bit;
   logic ev_rx_done, ev_frame, ev_parity, ev_break, ev_coll;

   // AXI4-Lite write path: address and data taken in either order
   logic aw_held_ff, w_held_ff, bvalid_ff;
   logic [ppp_pkg::ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;

   assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
   wire [7:0] wr_word = {awaddr_ff[7:2], 2'b00};
   wire wr_ctrl = wr_fire & (wr_word == ppp_pkg::OFF_CTRL);
   wire wr_status = wr_fire & (wr_word == ppp_pkg::OFF_STATUS);
   wire wr_rxdata = wr_fire & (wr_word == ppp_pkg::OFF_RXDATA);
   wire wr_txdata = wr_fire & (wr_word == ppp_pkg::OFF_TXDATA);
   wire wr_mapped = wr_ctrl | wr_status | wr_rxdata | wr_txdata;

   wire rd_fire = s_axi_arvalid & s_axi_arready;
   wire [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
   wire rd_ctrl = rd_word == ppp_pkg::OFF_CTRL;
   wire rd_status = rd_word == ppp_pkg::OFF_STATUS;
   wire rd_rxdata = rd_word == ppp_pkg::OFF_RXDATA;
   wire rd_txdata = rd_word == ppp_pkg::OFF_TXDATA;
   wire rd_mapped = rd_ctrl | rd_status | rd_rxdata | rd_txdata;

   wire tx_busy = (state_ff == ppp_pkg::ST_GUARD) | (state_ff == ppp_pkg::ST_TRANSMIT);
   wire [31:0] ctrl_word = {16'h0000, guard_ff, 7'h00, nvm_en_ff};
   wire [31:0] status_word = {24'h000000, port_en_ff, tx_busy, err_ff, sticky_ff};
   wire [31:0] rd_mux = rd_ctrl ? ctrl_word :
                        rd_status ? status_word :
                        rd_rxdata ? {24'h000000, rx_data_ff} : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bresp_ff <= ppp_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? ppp_pkg::RESP_OKAY : ppp_pkg::RESP_SLVERR;
         end else if (bvalid_ff & s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= ppp_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux;
         rresp_ff <= rd_mapped ? ppp_pkg::RESP_OKAY : ppp_pkg::RESP_SLVERR;
      end else if (rvalid_ff & s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Transmit command from software; refused while busy, in error or disabled
   wire tx_cmd = wr_txdata & wstrb_ff[0];
   wire tx_start = tx_cmd & port_en_ff & ~err_ff & (state_ff == ppp_pkg::ST_WAIT_START);
   wire [7:0] tx_byte = wdata_ff[7:0];
   wire tx_parity = ^tx_byte;
   // Stop, stop, parity, data, start; shifted out from bit 0
   wire [11:0] tx_frame = {2'b11, tx_parity, tx_byte, 1'b0};

   // Port enable: held by reset pin low or high voltage, power-down always ends it
   wire pin_enable = ~rst_s2_ff | hv_s2_ff;
   wire nxt_port_en = pin_enable | (nvm_en_ff & port_en_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nvm_en_ff <= ppp_pkg::NVM_EN_RST;
         guard_ff <= ppp_pkg::GUARD_RST;
         port_en_ff <= 1'b0;
      end else begin
         if (wr_ctrl & wstrb_ff[0]) begin
            nvm_en_ff <= wdata_ff[ppp_pkg::CTRL_NVM_BIT];
         end
         if (wr_ctrl & wstrb_ff[1]) begin
            guard_ff <= wdata_ff[ppp_pkg::CTRL_GUARD_LSB +: ppp_pkg::CTRL_GUARD_W];
         end
         port_en_ff <= nxt_port_en;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_guard_cnt = guard_cnt_ff;
      nxt_rx_sr = rx_sr_ff;
      nxt_par = par_ff;
      nxt_par_ok = par_ok_ff;
      nxt_stop_ok = stop_ok_ff;
      nxt_all_zero = all_zero_ff;
      nxt_tx_sr = tx_sr_ff;
      nxt_out = out_ff;
      nxt_oe = oe_ff;
      nxt_prev_bit = prev_bit_ff;
      ev_rx_done = 1'b0;
      ev_frame = 1'b0;
      ev_parity = 1'b0;
      ev_break = 1'b0;
      ev_coll = 1'b0;
      case (state_ff)
         ppp_pkg::ST_WAIT_START: begin
            if (tx_start) begin
               nxt_tx_sr = tx_frame;
               nxt_guard_cnt = {1'b0, guard_ff} + ppp_pkg::EXTRA_IDLE_BITS;
               nxt_prev_bit = 1'b1;
               nxt_state = ppp_pkg::ST_GUARD;
            end else if (link_rise & ~line_bit) begin
               nxt_bit_cnt = 4'h1;
               nxt_par = 1'b0;
               nxt_stop_ok = 1'b1;
               nxt_all_zero = 1'b1;
               nxt_state = ppp_pkg::ST_RECEIVE;
            end
         end
         ppp_pkg::ST_RECEIVE: begin
            if (link_rise) begin
               nxt_bit_cnt = bit_cnt_ff + 4'h1;
               nxt_all_zero = all_zero_ff & ~line_bit;
               if (bit_cnt_ff < ppp_pkg::BIT_PARITY) begin
                  nxt_rx_sr = {line_bit, rx_sr_ff[7:1]};
                  nxt_par = par_ff ^ line_bit;
               end else if (bit_cnt_ff == ppp_pkg::BIT_PARITY) begin
                  nxt_par_ok = (par_ff == line_bit);
               end else if (bit_cnt_ff == ppp_pkg::BIT_STOP1) begin
                  nxt_stop_ok = stop_ok_ff & line_bit;
               end else begin
                  nxt_state = ppp_pkg::ST_WAIT_START;
                  if (all_zero_ff & ~line_bit) begin
                     ev_break = 1'b1;
                     nxt_state = ppp_pkg::ST_BREAK_END;
                  end else if (~stop_ok_ff | ~line_bit | ~par_ok_ff) begin
                     ev_frame = ~stop_ok_ff | ~line_bit;
                     ev_parity = ~par_ok_ff;
                  end else begin
                     ev_rx_done = 1'b1;
                  end
               end
            end
         end
         ppp_pkg::ST_BREAK_END: begin
            // A break may run past twelve bits; do not take its tail as a start
            if (link_rise & line_bit) begin
               nxt_state = ppp_pkg::ST_WAIT_START;
            end
         end
         ppp_pkg::ST_GUARD: begin
            if (link_fall) begin
               if (guard_cnt_ff == 9'h000) begin
                  nxt_out = tx_sr_ff[0];
                  nxt_oe = 1'b1;
                  nxt_prev_bit = tx_sr_ff[0];
                  nxt_tx_sr = {1'b1, tx_sr_ff[11:1]};
                  nxt_bit_cnt = 4'h1;
                  nxt_state = ppp_pkg::ST_TRANSMIT;
               end else begin
                  nxt_guard_cnt = guard_cnt_ff - 9'h001;
               end
            end
         end
         ppp_pkg::ST_TRANSMIT: begin
            if (link_rise & ~oe_ff & ~line_bit) begin
               ev_coll = 1'b1;
               nxt_oe = 1'b0;
               nxt_out = 1'b1;
               nxt_state = ppp_pkg::ST_WAIT_START;
            end else if (link_fall) begin
               if (bit_cnt_ff == ppp_pkg::BIT_TX_END) begin
                  nxt_oe = 1'b0;
                  nxt_out = 1'b1;
                  nxt_state = ppp_pkg::ST_WAIT_START;
               end else begin
                  nxt_out = tx_sr_ff[0];
                  nxt_oe = ~tx_sr_ff[0] | ~prev_bit_ff;
                  nxt_prev_bit = tx_sr_ff[0];
                  nxt_tx_sr = {1'b1, tx_sr_ff[11:1]};
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
               end
            end
         end
         default: begin
            nxt_state = ppp_pkg::ST_WAIT_START;
            nxt_oe = 1'b0;
         end
      endcase
      // Disabled port drops everything back to idle receive
      if (!port_en_ff) begin
         nxt_state = ppp_pkg::ST_WAIT_START;
         nxt_oe = 1'b0;
         nxt_out = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ppp_pkg::ST_WAIT_START;
         bit_cnt_ff <= 4'h0;
         guard_cnt_ff <= 9'h000;
         rx_sr_ff <= 8'h00;
         par_ff <= 1'b0;
         par_ok_ff <= 1'b1;
         stop_ok_ff <= 1'b1;
         all_zero_ff <= 1'b0;
         tx_sr_ff <= 12'hfff;
         out_ff <= 1'b1;
         oe_ff <= 1'b0;
         prev_bit_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         guard_cnt_ff <= nxt_guard_cnt;
         rx_sr_ff <= nxt_rx_sr;
         par_ff <= nxt_par;
         par_ok_ff <= nxt_par_ok;
         stop_ok_ff <= nxt_stop_ok;
         all_zero_ff <= nxt_all_zero;
         tx_sr_ff <= nxt_tx_sr;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         prev_bit_ff <= nxt_prev_bit;
      end
   end

   assign prog_data_line_out = out_ff;
   assign prog_data_line_oe = oe_ff;

   // Error state and sticky flags; a hardware set wins over a software clear
   wire any_exc = ev_frame | ev_parity | ev_coll;
   wire nxt_err = port_en_ff & ~ev_break & (err_ff | any_exc);
   wire rx_accept = ev_rx_done & ~err_ff;
   wire [ppp_pkg::ST_STICKY_W-1:0] sticky_set = {ev_coll, ev_break, ev_parity, ev_frame, rx_accept};
   wire rx_read = rd_fire & rd_rxdata;
   wire [ppp_pkg::ST_STICKY_W-1:0] sticky_clr =
      (wr_status & wstrb_ff[0]) ? wdata_ff[ppp_pkg::ST_STICKY_W-1:0] : {ppp_pkg::ST_STICKY_W{1'b0}};
   wire [ppp_pkg::ST_STICKY_W-1:0] read_clr = {{(ppp_pkg::ST_STICKY_W-1){1'b0}}, rx_read};
   wire [ppp_pkg::ST_STICKY_W-1:0] nxt_sticky = (sticky_ff & ~(sticky_clr | read_clr)) | sticky_set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_ff <= 1'b0;
         sticky_ff <= {ppp_pkg::ST_STICKY_W{1'b0}};
         rx_data_ff <= 8'h00;
      end else begin
         err_ff <= nxt_err;
         sticky_ff <= nxt_sticky;
         if (rx_accept) begin
            rx_data_ff <= rx_sr_ff;
         end
      end
   end
endmodule // ppp_serial_phy
`default_nettype wire

// [pkg/ppp_pkg.sv]
// Constants for the serial programming port physical layer
`default_nettype none
package ppp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_RXDATA = 8'h08;
   localparam logic [7:0] OFF_TXDATA = 8'h0c;
   localparam int ADDR_W = 8;
   // Control fields
   localparam int CTRL_NVM_BIT = 0;
   localparam int CTRL_GUARD_LSB = 8;
   localparam int CTRL_GUARD_W = 8;
   localparam logic [7:0] GUARD_RST = 8'h80;
   localparam logic NVM_EN_RST = 1'b0;
   // Status fields
   localparam int ST_RX_VALID = 0;
   localparam int ST_FRAME_ERR = 1;
   localparam int ST_PARITY_ERR = 2;
   localparam int ST_BREAK = 3;
   localparam int ST_COLLISION = 4;
   localparam int ST_ERR_STATE = 5;
   localparam int ST_TX_BUSY = 6;
   localparam int ST_PORT_EN = 7;
   localparam int ST_STICKY_W = 5;
   // Frame shape
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS = 12;
   localparam logic [3:0] BIT_PARITY = 4'h9;
   localparam logic [3:0] BIT_STOP1 = 4'ha;
   localparam logic [3:0] BIT_STOP2 = 4'hb;
   localparam logic [3:0] BIT_TX_END = 4'hc;
   localparam logic [8:0] EXTRA_IDLE_BITS = 9'h002;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      ST_WAIT_START = 3'b000,
      ST_RECEIVE = 3'b001,
      ST_BREAK_END = 3'b010,
      ST_GUARD = 3'b011,
      ST_TRANSMIT = 3'b100
   } ppp_state_type;
endpackage
`default_nettype wire

// [verification/ppp_prog_model.sv]
// Programmer model: port clock, frames out, capture in
`timescale 1ns/1ps
`default_nettype none
module ppp_prog_model (
   output logic prog_clk,
   output logic drv_oe,
   output logic drv_val,
   input wire logic line,
   input wire logic dev_oe
);
   // Clock stands still high between bit cycles
   initial begin
      prog_clk = 1'h1;
      drv_oe = 1'h0;
      drv_val = 1'h1;
   end
   // Long low phase leaves the device time to settle
   task automatic bit_cyc(input logic oe, input logic v, output logic s, output logic so);
      prog_clk = 1'h0;
      drv_oe = oe;
      drv_val = v;
      #250;
      prog_clk = 1'h1;
      s = line;
      so = dev_oe;
      #150;
   endtask
   task automatic idle(input int n);
      logic s, so;
      repeat (n) bit_cyc(1'h0, 1'h1, s, so);
   endtask
   task automatic send(input logic [11:0] f);
      logic s, so;
      for (int i = 0; i < 12; i++) bit_cyc(1'h1, f[i], s, so);
      idle(1);
   endtask
   task automatic send_frame(input logic [7:0] d, input logic bp, input logic bs);
      send({1'h1, !bs, ^d ^ bp, d, 1'h0});
   endtask
   task automatic send_break();
      send(12'h000);
   endtask
   task automatic recv(input int col, output int idles, output logic [11:0] f, output logic [11:0] fo);
      logic s, so;
      idles = 0;
      bit_cyc(1'h0, 1'h1, s, so);
      while (s && idles < 200) begin
         idles++;
         bit_cyc(1'h0, 1'h1, s, so);
      end
      f[0] = s;
      fo[0] = so;
      // Optional low drive on one bit to force a collision
      for (int i = 1; i < 12; i++) bit_cyc(i == col, 1'h0, f[i], fo[i]);
      idle(1);
   endtask
endmodule // ppp_prog_model
`default_nettype wire

// [verification/ppp_serial_phy_monitor.sv]
// Bus and data line checks for the programming port
`timescale 1ns/1ps
`default_nettype none
module ppp_serial_phy_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [ppp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [ppp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic prog_clock_in,
   input wire logic prog_data_line_out,
   input wire logic prog_data_line_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // A driven one may last one bit period only
   logic [3:0] one_cnt_ff;
   logic [3:0] nxt_one_cnt;
   assign nxt_one_cnt = !(prog_data_line_oe && prog_data_line_out) ? 4'h0 :
      (one_cnt_ff == 4'hf ? one_cnt_ff : one_cnt_ff + 4'h1);
   always_ff @(posedge aclk) one_cnt_ff <= aresetn ? nxt_one_cnt : 4'h0;
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr >= 8'h10;
   endsequence
   sequence slverr_s;
      s_axi_bvalid && s_axi_bresp == ppp_pkg::RESP_SLVERR;
   endsequence
   sequence rd_take_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   reset_recv_a: assert property ($rose(aresetn) |-> (!prog_data_line_oe && prog_data_line_out) [*8])
      else $error("line driven after reset");
   drive_edge_a: assert property ($rose(prog_data_line_oe) |-> !prog_clock_in)
      else $error("driver enabled while port clock high");
   ones_release_a: assert property (one_cnt_ff <= 4'h9)
      else $error("one driven longer than a bit");
   unmapped_wr_a: assert property (wr_take_s |-> ##[1:3] slverr_s)
      else $error("unmapped write not refused");
   unmapped_rd_a: assert property (rd_take_s ##0 s_axi_araddr >= 8'h10 |=>
      s_axi_rvalid && s_axi_rresp == ppp_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
      else $error("read answer late");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
endmodule // ppp_serial_phy_monitor
bind ppp_serial_phy ppp_serial_phy_monitor ppp_serial_phy_monitor_i (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .prog_clock_in,
   .prog_data_line_out, .prog_data_line_oe);
`default_nettype wire

// [verification/ppp_serial_phy_tb.sv]
// Self-checking bench for the programming port physical layer
`timescale 1ns/1ps
`default_nettype none
module ppp_serial_phy_tb;
   typedef struct packed {logic [7:0] d; logic bp; logic bs; logic [7:0] st; logic [7:0] rx;} ppp_row_type;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, prog_reset_n = 1'h1, prog_reset_hv = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic prog_clock_in, drv_oe, drv_val, dout, doe, line;
   logic [11:0] f, fo;
   int idl, fails = 0, cmp_count = 0;
   ppp_row_type rows [7] = '{'{8'h01, 1'h0, 1'h0, 8'h81, 8'h01}, '{8'ha5, 1'h0, 1'h0, 8'h81, 8'ha5},
      '{8'h00, 1'h0, 1'h0, 8'h81, 8'h00}, '{8'h80, 1'h0, 1'h0, 8'h81, 8'h80},
      '{8'h3c, 1'h1, 1'h0, 8'ha4, 8'h80}, '{8'h3c, 1'h0, 1'h1, 8'ha2, 8'h80},
      '{8'h3c, 1'h1, 1'h1, 8'ha6, 8'h80}};
   // Pull-up wins when nobody drives
   assign line = doe ? dout : (drv_oe ? drv_val : 1'h1);
   always #25 aclk = !aclk;
   ppp_serial_phy ppp_serial_phy_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .prog_clock_in, .prog_data_line_in(line), .prog_data_line_out(dout),
      .prog_data_line_oe(doe), .prog_reset_n, .prog_reset_hv);
   ppp_prog_model ppp_prog_model_i (.prog_clk(prog_clock_in), .drv_oe, .drv_val, .line, .dev_oe(doe));
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic awp, wp;
      @(posedge aclk);
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_bready <= 1'h1;
      awp = 1'h1;
      wp = 1'h1;
      while (awp || wp) begin
         @(posedge aclk);
         if (awp && s_axi_awready === 1'h1) begin
            awp = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (wp && s_axi_wready === 1'h1) begin
            wp = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end
      while (s_axi_bvalid !== 1'h1) @(posedge aclk);
      s_axi_bready <= 1'h0;
      chk($sformatf("bresp %h", a), {30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk($sformatf("rdata %h", a), s_axi_rdata, e);
      chk($sformatf("rresp %h", a), {30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task do_tx(input logic [7:0] d, input int g);
      logic [11:0] ef, eo;
      ef = {2'h3, ^d, d, 1'h0};
      eo[0] = 1'h1;
      for (int k = 1; k < 12; k++) eo[k] = !ef[k] || !ef[k-1];
      wr_chk(ppp_pkg::OFF_TXDATA, {24'h0, d}, 4'hf, ppp_pkg::RESP_OKAY);
      #13 ppp_prog_model_i.recv(0, idl, f, fo);
      chk("idle bits", idl, g + 2);
      chk("frame", {20'h0, f}, {20'h0, ef});
      chk("drive", {20'h0, fo}, {20'h0, eo});
      rd_chk(ppp_pkg::OFF_STATUS, 32'h80, ppp_pkg::RESP_OKAY);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      rd_chk(ppp_pkg::OFF_CTRL, 32'h8000, ppp_pkg::RESP_OKAY);
      rd_chk(ppp_pkg::OFF_STATUS, 32'h0, ppp_pkg::RESP_OKAY);
      rd_chk(8'h10, 32'h0, ppp_pkg::RESP_SLVERR);
      wr_chk(8'h10, 32'hffffffff, 4'hf, ppp_pkg::RESP_SLVERR);
      prog_reset_n <= 1'h0;
      #13 ppp_prog_model_i.idle(16);
      rd_chk(ppp_pkg::OFF_STATUS, 32'h80, ppp_pkg::RESP_OKAY);
      do_tx(8'ha5, 128);
      wr_chk(ppp_pkg::OFF_CTRL, 32'h0, 4'hf, ppp_pkg::RESP_OKAY);
      rd_chk(ppp_pkg::OFF_CTRL, 32'h0, ppp_pkg::RESP_OKAY);
      do_tx(8'h01, 0);
      do_tx(8'h6e, 0);
      foreach (rows[i]) begin
         #13 ppp_prog_model_i.send_frame(rows[i].d, rows[i].bp, rows[i].bs);
         rd_chk(ppp_pkg::OFF_STATUS, {24'h0, rows[i].st}, ppp_pkg::RESP_OKAY);
         if (rows[i].st[5] === 1'h1) begin
            #13 ppp_prog_model_i.send_frame(8'h55, 1'h0, 1'h0);
            rd_chk(ppp_pkg::OFF_STATUS, {24'h0, rows[i].st}, ppp_pkg::RESP_OKAY);
            #13 ppp_prog_model_i.send_break();
            rd_chk(ppp_pkg::OFF_STATUS, {24'h0, (rows[i].st & 8'hdf) | 8'h08}, ppp_pkg::RESP_OKAY);
            wr_chk(ppp_pkg::OFF_STATUS, 32'h1f, 4'hf, ppp_pkg::RESP_OKAY);
         end
         rd_chk(ppp_pkg::OFF_RXDATA, {24'h0, rows[i].rx}, ppp_pkg::RESP_OKAY);
         rd_chk(ppp_pkg::OFF_STATUS, 32'h80, ppp_pkg::RESP_OKAY);
      end
      wr_chk(ppp_pkg::OFF_TXDATA, 32'hff, 4'hf, ppp_pkg::RESP_OKAY);
      #13 ppp_prog_model_i.recv(2, idl, f, fo);
      chk("driver off", {31'h0, doe}, 32'h0);
      wr_chk(ppp_pkg::OFF_TXDATA, 32'h0f, 4'hf, ppp_pkg::RESP_OKAY);
      rd_chk(ppp_pkg::OFF_STATUS, 32'hb0, ppp_pkg::RESP_OKAY);
      #13 ppp_prog_model_i.send_break();
      rd_chk(ppp_pkg::OFF_STATUS, 32'h98, ppp_pkg::RESP_OKAY);
      wr_chk(ppp_pkg::OFF_STATUS, 32'h1f, 4'hf, ppp_pkg::RESP_OKAY);
      // Memory access enable keeps the port alive across pin release
      wr_chk(ppp_pkg::OFF_CTRL, 32'h1, 4'hf, ppp_pkg::RESP_OKAY);
      prog_reset_n <= 1'h1;
      repeat (8) @(posedge aclk);
      rd_chk(ppp_pkg::OFF_STATUS, 32'h80, ppp_pkg::RESP_OKAY);
      prog_reset_n <= 1'h0;
      repeat (8) @(posedge aclk);
      wr_chk(ppp_pkg::OFF_CTRL, 32'h0, 4'hf, ppp_pkg::RESP_OKAY);
      prog_reset_n <= 1'h1;
      repeat (8) @(posedge aclk);
      rd_chk(ppp_pkg::OFF_STATUS, 32'h0, ppp_pkg::RESP_OKAY);
      report_and_stop();
   end
   // Run needs well under half of this span
   initial begin
      #1000000;
      fails++;
      report_and_stop();
   end
endmodule // ppp_serial_phy_tb
`default_nettype wire
